// [hdl/rps_consts.svh]
// Register offsets, field positions and reset values of the port page select logic.
// Assumes 8-bit register addresses and 8-bit register data.
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

// Register offsets.
`define RPS_ADDR_PAGE_SEL 8'h4C
`define RPS_ADDR_STS_PRI 8'h4D

// Fields of port_page_select.
`define RPS_SEL_LINKED_HI 7
`define RPS_SEL_LINKED_LO 6
`define RPS_SEL_RDSEL_BIT 4
`define RPS_SEL_WEN1_BIT 1
`define RPS_SEL_WEN0_BIT 0

// Fields of receive_port_status_primary.
`define RPS_STS_PORTNUM_BIT 6
`define RPS_STS_CRC_BIT 5
`define RPS_STS_CHG_BIT 4
`define RPS_STS_LOCK_BIT 0

// Context reset values: local I2C, control channel on port 0, on port 1.
`define RPS_CTX_LOCAL 2'h0
`define RPS_CTX_CHAN0 2'h1
`define RPS_CTX_CHAN1 2'h2
`define RPS_RDSEL_RST 3'h4
`define RPS_WEN_LOCAL_RST 2'h0
`define RPS_WEN_CHAN0_RST 2'h1
`define RPS_WEN_CHAN1_RST 2'h2

`endif

// [hdl/rps_pkg.sv]
// Types shared by the port page select logic.
// Assumes the constants header is included by each design file that needs numbers.
package rps_pkg;

   // One register access, from local I2C or from a remote serializer.
   typedef struct packed {
      logic via_chan;
      logic chan_port;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rps_req_t;

   // Sticky status of one receive port.
   typedef struct packed {
      logic crc_flag;
      logic chg_flag;
      logic irq;
   } rps_port_sts_t;

endpackage : rps_pkg

// [hdl/rps_port_status.sv]
// Sticky status flags of one receive port: control channel CRC error and lock change.
// Assumes lock and error inputs are synchronous to i_clk; i_clr is a one-cycle read strobe.
`timescale 1ns/1ps
module rps_port_status
   import rps_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Link events of this port.
   input wire logic i_lock,
   input wire logic i_crc_err,
   // Read of the status register for this port.
   input wire logic i_clr,
   // Flags.
   output rps_port_sts_t o_sts
);

   logic lock_prev;
   logic lock_chg;
   logic next_crc;
   logic next_chg;

   // The previous lock level starts unlocked, so a lock present at reset counts as a change.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lock_prev <= 1'b0;
      end else begin
         lock_prev <= i_lock;
      end
   end

   assign lock_chg = i_lock ^ lock_prev;

   // A new event in the clearing cycle wins, so no event is ever lost to a read.
   assign next_crc = i_crc_err | (o_sts.crc_flag & ~i_clr);
   assign next_chg = lock_chg | (o_sts.chg_flag & ~i_clr);

   // Flags and the pending indication share one edge so they never disagree.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sts <= '0;
      end else begin
         o_sts.crc_flag <= next_crc;
         o_sts.chg_flag <= next_chg;
         o_sts.irq <= next_crc | next_chg;
      end
   end

endmodule : rps_port_status

// [hdl/rps_port_page_regs.sv]
// Port page select and first receive-port status registers of a two-port deserializer.
// Assumes one access per cycle from an I2C or control-channel front end, synchronous inputs.
//
// Functional notes
// - Linked port field bits 7:6 is read-only and reads zero over local I2C.
// - Over the control channel it returns the receive port the access came through.
// - Readback select bit 4 picks port 0 or port 1 for paged register reads.
// - Readback select defaults to 0 locally, to the carrying port over the channel.
// - Bit 1 gates port 1 paged writes; one write reaches every enabled port.
// - Bit 0 gates port 0 paged writes; both enables reset to zero locally.
// - Over the channel, the carrying port's write enable defaults to one.
// - Status bit 6 is read-only and shows the port selected for readback.
// - Status bit 5 latches a control channel CRC error, cleared on read.
// - Status bit 4 latches any lock state change since last read, cleared on read.
// - Status bit 0 shows the present lock state of the receiver.
// - Each port raises a pending indication on events, cleared by reading the status.
`timescale 1ns/1ps
`include "rps_consts.svh"
module rps_port_page_regs
   import rps_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Register access from local I2C or from the control channel.
   input wire logic i_req_valid,
   input wire rps_req_t i_req,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_rdata,
   // Link events of the two receive ports.
   input wire logic [1:0] i_lock,
   input wire logic [1:0] i_crc_err,
   // Steering toward the paged register blocks of each port.
   output logic [1:0] o_paged_wr,
   output logic [7:0] o_paged_addr,
   output logic [7:0] o_paged_wdata,
   output logic o_paged_rd_port,
   // Per-port pending indications.
   output logic [1:0] o_irq_pending
);

   // Each access path keeps its own page context so a remote serializer cannot
   // disturb the local host's selection, at the cost of three small copies.
   function automatic logic [1:0] ctx_of(input logic via, input logic port);
      ctx_of = via ? (port ? `RPS_CTX_CHAN1 : `RPS_CTX_CHAN0) : `RPS_CTX_LOCAL;
   endfunction : ctx_of

   logic [2:0] ctx_rd;
   logic [1:0] ctx_wen [3];
   logic [1:0] cur_cx;
   logic cur_sel;
   logic [1:0] cur_wen;
   logic sel_wr;
   logic sts_rd;
   logic paged_wr;
   logic [1:0] sts_clr;
   logic [7:0] next_rdata;
   rps_port_sts_t sts [2];

   assign cur_cx = ctx_of(i_req.via_chan, i_req.chan_port);
   assign cur_sel = ctx_rd[cur_cx];
   assign cur_wen = ctx_wen[cur_cx];
   assign sel_wr = i_req_valid & i_req.we & (i_req.addr == `RPS_ADDR_PAGE_SEL);
   assign sts_rd = i_req_valid & ~i_req.we & (i_req.addr == `RPS_ADDR_STS_PRI);
   assign paged_wr = i_req_valid & i_req.we & (i_req.addr != `RPS_ADDR_PAGE_SEL);
   assign sts_clr = sts_rd ? (cur_sel ? 2'h2 : 2'h1) : 2'h0;

   // Page context: only the readback select and the write enables are stored.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctx_rd <= `RPS_RDSEL_RST;
         ctx_wen[0] <= `RPS_WEN_LOCAL_RST;
         ctx_wen[1] <= `RPS_WEN_CHAN0_RST;
         ctx_wen[2] <= `RPS_WEN_CHAN1_RST;
      end else if (sel_wr) begin
         ctx_rd[cur_cx] <= i_req.wdata[`RPS_SEL_RDSEL_BIT];
         ctx_wen[cur_cx] <= {i_req.wdata[`RPS_SEL_WEN1_BIT], i_req.wdata[`RPS_SEL_WEN0_BIT]};
      end
   end

   // The readback port is steered with the request itself, so it is combinational.
   assign o_paged_rd_port = cur_sel;

   // Paged writes go to every port whose enable is set; the status register itself
   // has no writable bit, so its write only reaches the outside blocks.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_paged_wr <= 2'h0;
         o_paged_addr <= 8'h00;
         o_paged_wdata <= 8'h00;
      end else begin
         o_paged_wr <= paged_wr ? cur_wen : 2'h0;
         o_paged_addr <= i_req.addr;
         o_paged_wdata <= i_req.wdata;
      end
   end

   // Status flags of both ports, cleared only when the selected port is read.
   for (genvar p = 0; p < 2; p++) begin : g_port
      rps_port_status u_sts (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_lock(i_lock[p]),
         .i_crc_err(i_crc_err[p]),
         .i_clr(sts_clr[p]),
         .o_sts(sts[p])
      );
      assign o_irq_pending[p] = sts[p].irq;
   end

   // Read data; reserved bits and unknown addresses read as zero, and writes to
   // read-only fields have nowhere to land.
   always_comb begin
      next_rdata = 8'h00;
      if (i_req.addr == `RPS_ADDR_PAGE_SEL) begin
         next_rdata[`RPS_SEL_LINKED_HI:`RPS_SEL_LINKED_LO] =
            i_req.via_chan ? {1'b0, i_req.chan_port} : 2'h0;
         next_rdata[`RPS_SEL_RDSEL_BIT] = cur_sel;
         next_rdata[`RPS_SEL_WEN1_BIT] = cur_wen[1];
         next_rdata[`RPS_SEL_WEN0_BIT] = cur_wen[0];
      end else if (i_req.addr == `RPS_ADDR_STS_PRI) begin
         next_rdata[`RPS_STS_PORTNUM_BIT] = cur_sel;
         next_rdata[`RPS_STS_CRC_BIT] = sts[cur_sel].crc_flag;
         next_rdata[`RPS_STS_CHG_BIT] = sts[cur_sel].chg_flag;
         next_rdata[`RPS_STS_LOCK_BIT] = i_lock[cur_sel];
      end
   end

   // One answer per request, one cycle later; writes answer too, with zero data.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rsp_valid <= 1'b0;
         o_rsp_rdata <= 8'h00;
      end else begin
         o_rsp_valid <= i_req_valid;
         o_rsp_rdata <= (i_req_valid & ~i_req.we) ? next_rdata : 8'h00;
      end
   end

   // Helper marking the first clock after reset release.
   logic first_cyc;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         first_cyc <= 1'b1;
      end else begin
         first_cyc <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   AST_LINKED_LOCAL_ZERO: assert property (
      (i_req_valid && !i_req.we && i_req.addr == `RPS_ADDR_PAGE_SEL && !i_req.via_chan)
      |=> o_rsp_valid && o_rsp_rdata[7:6] == 2'h0)
      else $error("Linked port field not zero on local read.");

   AST_LINKED_REMOTE_PORT: assert property (
      (i_req_valid && !i_req.we && i_req.addr == `RPS_ADDR_PAGE_SEL && i_req.via_chan)
      |=> o_rsp_rdata[7:6] == {1'b0, $past(i_req.chan_port)})
      else $error("Linked port field does not name the carrying port.");

   AST_RDSEL_DEFAULT: assert property (
      first_cyc |-> ctx_rd == 3'h4)
      else $error("Readback select defaults wrong after reset.");

   AST_WEN_LOCAL_RESET: assert property (
      first_cyc |-> ctx_wen[0] == 2'h0)
      else $error("Local write enables not zero after reset.");

   AST_WEN_CHAN_DEFAULT: assert property (
      first_cyc |-> ctx_wen[1] == 2'h1 && ctx_wen[2] == 2'h2)
      else $error("Channel write enable defaults wrong.");

   AST_PAGED_WR_GATE: assert property (
      paged_wr |=> o_paged_wr == $past(cur_wen) ##1 o_paged_wr == 2'h0 || $past(paged_wr))
      else $error("Paged write not gated by the enables.");

   AST_STS_PORTNUM: assert property (
      sts_rd |=> o_rsp_rdata[6] == $past(cur_sel))
      else $error("Status port number differs from readback select.");

   AST_CRC_LATCH: assert property (
      i_crc_err[0] |=> sts[0].crc_flag [*1] ##0 o_irq_pending[0])
      else $error("CRC error not latched or not pending.");

   AST_CRC_CLEAR: assert property (
      (sts_clr[0] && !i_crc_err[0]) |=> !sts[0].crc_flag)
      else $error("CRC flag not cleared by read.");

   AST_LOCK_CHANGE: assert property (
      (i_lock[1] != $past(i_lock[1])) |=> sts[1].chg_flag)
      else $error("Lock change not latched.");

   AST_LOCK_LIVE: assert property (
      sts_rd |=> o_rsp_rdata[0] == $past(i_lock[cur_sel]))
      else $error("Lock state bit does not follow the selected port.");

   AST_IRQ_CLEAR: assert property (
      (sts_clr[1] && !i_crc_err[1] && i_lock[1] == $past(i_lock[1])) |=> !o_irq_pending[1])
      else $error("Pending not cleared by status read.");

   AST_RO_WRITE: assert property (
      (i_req_valid && i_req.we && i_req.addr == `RPS_ADDR_STS_PRI && !i_crc_err[0])
      |=> $stable(sts[0].crc_flag) || !$past(sts[0].crc_flag))
      else $error("Write disturbed a read-only flag.");

   // A read in the cycle of a new event must not swallow that event.
   AST_SET_WINS: assert property (
      (sts_clr[0] && i_crc_err[0]) |=> sts[0].crc_flag && o_irq_pending[0])
      else $error("CRC event lost to a clearing read.");

   AST_PAGED_FORWARD: assert property (
      paged_wr |=> o_paged_addr == $past(i_req.addr) && o_paged_wdata == $past(i_req.wdata))
      else $error("Paged write address or data not forwarded.");

   COV_REMOTE_READ: cover property (i_req_valid && i_req.via_chan && !i_req.we);
   COV_DUAL_WRITE: cover property (o_paged_wr == 2'h3);
   COV_SET_ON_CLEAR: cover property (sts_clr[0] && i_crc_err[0]);
   COV_PORT1_READBACK: cover property (sts_rd && cur_sel);

endmodule : rps_port_page_regs

// [bench/rps_host_model.sv]
// Host side model: a local I2C host or a remote serializer issuing register accesses.
// Assumes the register logic answers on the edge that takes a request, read half a cycle later.
`timescale 1ns/1ps
module rps_host_model
   import rps_pkg::*;
(
   // Clock.
   input wire logic i_clk,
   // Request side.
   output logic o_req_valid,
   output rps_req_t o_req,
   // Answer side.
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_rdata
);
   // Idle until the first access.
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end
   // One access; m is {via channel, carrying port, write}.
   // The request fields are scrambled after release so that stale data is never trusted.
   task automatic acc(input logic [2:0] m, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rdata);
      @(posedge i_clk);
      o_req_valid <= 1'b1;
      o_req <= '{m[2], m[1], m[0], a, d};
      @(posedge i_clk);
      o_req_valid <= 1'b0;
      o_req <= ~o_req;
      @(negedge i_clk);
      rdata = i_rsp_valid ? i_rsp_rdata : 8'hXX;
   endtask : acc
endmodule : rps_host_model

// [bench/rx_port_page_select_status_bench.sv]
// Self-checking bench of the port page select and status registers.
// Assumes the host model issues every access; link events are driven here.
`timescale 1ns/1ps
module rx_port_page_select_status_bench
   import rps_pkg::*;
;
   logic i_clk;
   logic i_rst_b;
   logic req_valid;
   rps_req_t req;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic [1:0] lock;
   logic [1:0] crc_err;
   logic [1:0] paged_wr;
   logic [1:0] irq;
   logic rd_port;
   logic port_seen;
   logic [7:0] paged_addr;
   logic [7:0] paged_wdata;
   logic [7:0] rd;
   int error_cnt;
   int compares;
   int cycles;

   // Register logic under test.
   rps_port_page_regs i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(req_valid), .i_req(req),
      .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .i_lock(lock),
      .i_crc_err(crc_err), .o_paged_wr(paged_wr), .o_paged_addr(paged_addr),
      .o_paged_wdata(paged_wdata), .o_paged_rd_port(rd_port), .o_irq_pending(irq)
   );

   // Far side that issues accesses.
   rps_host_model i_host (
      .i_clk(i_clk), .o_req_valid(req_valid), .o_req(req),
      .i_rsp_valid(rsp_valid), .i_rsp_rdata(rsp_rdata)
   );

   // Compare one value; four-state so an unknown never matches.
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Print the counts and the verdict, then stop.
   task automatic summarize();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // Clock of 10 ns.
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Hang guard; the tests need well under a hundred cycles.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         summarize();
      end
   end

   // The readback port follows the standing request, so it is caught mid-cycle where it
   // has settled rather than at the edge that changes the request.
   always @(negedge i_clk) begin
      if (req_valid) begin
         port_seen <= rd_port;
      end
   end

   // Test sequence.
   initial begin
      i_rst_b = 1'b0;
      lock = 2'h0;
      crc_err = 2'h0;
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      i_host.acc(3'h0, 8'h4C, 8'h00, rd);
      chk("sel local", rd, 8'h00);
      chk("rd port local", {7'h00, port_seen}, 8'h00);
      i_host.acc(3'h6, 8'h4C, 8'h00, rd);
      chk("sel chan1", rd, 8'h52);
      chk("rd port chan1", {7'h00, port_seen}, 8'h01);
      i_host.acc(3'h4, 8'h4C, 8'h00, rd);
      chk("sel chan0", rd, 8'h01);
      i_host.acc(3'h7, 8'h20, 8'hA5, rd);
      chk("wr chan1", {6'h00, paged_wr}, 8'h02);
      chk("wr chan1 addr", paged_addr, 8'h20);
      chk("wr chan1 data", paged_wdata, 8'hA5);
      i_host.acc(3'h1, 8'h20, 8'hA5, rd);
      chk("wr closed", {6'h00, paged_wr}, 8'h00);
      // All ones must leave read-only and reserved bits clear.
      i_host.acc(3'h1, 8'h4C, 8'hFF, rd);
      i_host.acc(3'h0, 8'h4C, 8'h00, rd);
      chk("sel ones", rd, 8'h13);
      chk("rd port ones", {7'h00, port_seen}, 8'h01);
      i_host.acc(3'h1, 8'h20, 8'h5A, rd);
      chk("wr both", {6'h00, paged_wr}, 8'h03);
      i_host.acc(3'h1, 8'h4C, 8'h01, rd);
      i_host.acc(3'h1, 8'h21, 8'h5A, rd);
      chk("wr port0", {6'h00, paged_wr}, 8'h01);
      chk("wr port0 addr", paged_addr, 8'h21);
      chk("wr port0 data", paged_wdata, 8'h5A);
      // Port 1 gains lock and sees one CRC error pulse.
      @(posedge i_clk);
      lock <= 2'h2;
      crc_err <= 2'h2;
      @(posedge i_clk);
      crc_err <= 2'h0;
      @(negedge i_clk);
      chk("irq set", {6'h00, irq}, 8'h02);
      i_host.acc(3'h6, 8'h4D, 8'h00, rd);
      chk("sts first", rd, 8'h71);
      i_host.acc(3'h6, 8'h4D, 8'h00, rd);
      chk("sts again", rd, 8'h41);
      chk("irq clear", {6'h00, irq}, 8'h00);
      i_host.acc(3'h7, 8'h4D, 8'hFF, rd);
      i_host.acc(3'h6, 8'h4D, 8'h00, rd);
      chk("sts written", rd, 8'h41);
      i_host.acc(3'h0, 8'h4D, 8'h00, rd);
      chk("sts port0", rd, 8'h00);
      // Port 0 CRC error held across a read: the read sees it and the flag survives.
      @(posedge i_clk);
      crc_err <= 2'h1;
      i_host.acc(3'h0, 8'h4D, 8'h00, rd);
      chk("sts crc0 first", rd, 8'h20);
      @(posedge i_clk);
      crc_err <= 2'h0;
      // Writing ones to the status register must leave the flag standing.
      i_host.acc(3'h1, 8'h4D, 8'hFF, rd);
      chk("irq port0", {6'h00, irq}, 8'h01);
      i_host.acc(3'h0, 8'h4D, 8'h00, rd);
      chk("sts crc0 kept", rd, 8'h20);
      chk("irq port0 clear", {6'h00, irq}, 8'h00);
      i_host.acc(3'h0, 8'h4D, 8'h00, rd);
      chk("sts crc0 clear", rd, 8'h00);
      summarize();
   end
endmodule : rx_port_page_select_status_bench
